// ---- inc/adcrw_pkg.sv ----
// package: register map, field positions and reset values of the result/window/reference bank
package adcrw_pkg;
  // special-function addresses, same on both register pages
  localparam logic [7:0] ADDR_CHAN_SEL   = 8'hBB;
  localparam logic [7:0] ADDR_RESULT_LO  = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HI  = 8'hBE;
  localparam logic [7:0] ADDR_UPPER_LO   = 8'hC3;
  localparam logic [7:0] ADDR_UPPER_HI   = 8'hC4;
  localparam logic [7:0] ADDR_LOWER_LO   = 8'hC5;
  localparam logic [7:0] ADDR_LOWER_HI   = 8'hC6;
  localparam logic [7:0] ADDR_REF_CTRL   = 8'hD1;
  // register pages on which the bank answers
  localparam logic [7:0] PAGE_LOW        = 8'h00;
  localparam logic [7:0] PAGE_HIGH       = 8'h10;
  // reset values
  localparam logic [7:0] RST_RESULT      = 8'h00;
  localparam logic [7:0] RST_UPPER       = 8'hFF;
  localparam logic [7:0] RST_LOWER       = 8'h00;
  localparam logic [4:0] RST_CHAN_SEL    = 5'h1F;
  localparam logic [7:0] RST_REF_CTRL    = 8'h18;
  // channel selector field
  localparam int         CHAN_MSB        = 4;
  // highest connected channel code; codes above are reserved (no input)
  localparam logic [4:0] CHAN_LAST_VALID = 5'h13;
  // reference control field positions
  localparam int         REF_LVL_BIT     = 7;
  localparam int         REF_GND_BIT     = 5;
  localparam int         REF_SEL_MSB     = 4;
  localparam int         REF_SEL_LSB     = 3;
  localparam int         REF_TEMP_BIT    = 2;
  // writable bits of the reference control register
  localparam logic [7:0] REF_CTRL_MASK   = 8'hBC;
  // justify/shift codes
  localparam logic [2:0] JS_RIGHT_0      = 3'h0;
  localparam logic [2:0] JS_RIGHT_3      = 3'h3;
  localparam logic [2:0] JS_LEFT         = 3'h4;
  // voltage reference choices
  typedef enum logic [1:0] {
    ADCRW_REF_PIN   = 2'h0,
    ADCRW_REF_VDD   = 2'h1,
    ADCRW_REF_LDO   = 2'h2,
    ADCRW_REF_INT   = 2'h3
  } adcrw_ref_type;
endpackage

// ---- rtl/adcrw_format.sv ----
// result formatter: justification and right shift of the 16-bit accumulator
module adcrw_format #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] acc,
  input  wire logic [2:0]       justify_shift_select,
  input  wire logic [3:0]       sample_bits_minus1,
  output logic      [WIDTH-1:0] formatted
);
  // right shift fills with zeros; left justify moves the sample to the top bits
  always_comb begin
    if (justify_shift_select == adcrw_pkg::JS_LEFT) begin
      formatted = acc << (4'(WIDTH - 1) - sample_bits_minus1);
    end else if (justify_shift_select <= adcrw_pkg::JS_RIGHT_3) begin
      formatted = acc >> justify_shift_select[1:0];
    end else begin
      formatted = acc; // reserved codes read unformatted
    end
  end
endmodule // adcrw_format

// ---- rtl/adcrw_regs.sv ----
// register bank: result bytes, window thresholds, channel select, reference control
////////////////////////////////////////////////////////////////////////////////
module adcrw_regs #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  // special-function register port
  input  wire logic [7:0]       sfr_page,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  output logic                  sfr_hit,
  // converter side
  input  wire logic             acc_load,
  input  wire logic [WIDTH-1:0] acc_data,
  input  wire logic [2:0]       justify_shift_select,
  input  wire logic [3:0]       sample_bits_minus1,
  output logic      [WIDTH-1:0] accumulator,
  output logic      [WIDTH-1:0] upper_limit,
  output logic      [WIDTH-1:0] lower_limit,
  output logic      [4:0]       positive_channel_select,
  output logic                  channel_connected,
  output logic                  internal_ref_level,
  output logic                  ground_ref_select,
  output adcrw_pkg::adcrw_ref_type voltage_ref_select,
  output logic                  temp_sensor_enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic             page_ok;
  logic [WIDTH-1:0] formatted;
  logic [7:0]       ref_ctrl;
  logic [7:0]       next_rdata;
  logic             next_hit;

  // both pages reach the same storage, no banking needed here
  assign page_ok = (sfr_page == adcrw_pkg::PAGE_LOW) ||
                   (sfr_page == adcrw_pkg::PAGE_HIGH);

  function automatic logic is_wr(input logic [7:0] a);
    is_wr = sfr_wr && page_ok && (sfr_addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // accumulator: software bytes win over a converter load in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accumulator <= {adcrw_pkg::RST_RESULT, adcrw_pkg::RST_RESULT};
    end else begin
      if (acc_load) begin
        accumulator <= acc_data;
      end
      if (is_wr(adcrw_pkg::ADDR_RESULT_HI)) begin
        accumulator[15:8] <= sfr_wdata;
      end
      if (is_wr(adcrw_pkg::ADDR_RESULT_LO)) begin
        accumulator[7:0] <= sfr_wdata;
      end
    end
  end

  // window thresholds
  always_ff @(posedge core_clk) begin
    if (rst) begin
      upper_limit <= {adcrw_pkg::RST_UPPER, adcrw_pkg::RST_UPPER};
      lower_limit <= {adcrw_pkg::RST_LOWER, adcrw_pkg::RST_LOWER};
    end else begin
      if (is_wr(adcrw_pkg::ADDR_UPPER_HI)) upper_limit[15:8] <= sfr_wdata;
      if (is_wr(adcrw_pkg::ADDR_UPPER_LO)) upper_limit[7:0] <= sfr_wdata;
      if (is_wr(adcrw_pkg::ADDR_LOWER_HI)) lower_limit[15:8] <= sfr_wdata;
      if (is_wr(adcrw_pkg::ADDR_LOWER_LO)) lower_limit[7:0] <= sfr_wdata;
    end
  end

  // channel select; reserved top bits are not stored and read as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      positive_channel_select <= adcrw_pkg::RST_CHAN_SEL;
      channel_connected       <= 1'b0;
    end else begin
      if (is_wr(adcrw_pkg::ADDR_CHAN_SEL)) begin
        positive_channel_select <= sfr_wdata[adcrw_pkg::CHAN_MSB:0];
        channel_connected <= (sfr_wdata[4:0] <= adcrw_pkg::CHAN_LAST_VALID);
      end
    end
  end

  // reference control; only documented fields are stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      internal_ref_level <= adcrw_pkg::RST_REF_CTRL[adcrw_pkg::REF_LVL_BIT];
      ground_ref_select  <= adcrw_pkg::RST_REF_CTRL[adcrw_pkg::REF_GND_BIT];
      voltage_ref_select <= adcrw_pkg::ADCRW_REF_INT;
      temp_sensor_enable <= adcrw_pkg::RST_REF_CTRL[adcrw_pkg::REF_TEMP_BIT];
    end else if (is_wr(adcrw_pkg::ADDR_REF_CTRL)) begin
      internal_ref_level <= sfr_wdata[adcrw_pkg::REF_LVL_BIT];
      ground_ref_select  <= sfr_wdata[adcrw_pkg::REF_GND_BIT];
      voltage_ref_select <= adcrw_pkg::adcrw_ref_type'(
        sfr_wdata[adcrw_pkg::REF_SEL_MSB:adcrw_pkg::REF_SEL_LSB]);
      temp_sensor_enable <= sfr_wdata[adcrw_pkg::REF_TEMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: formatting is applied live, so a mode change shows on the next read
  adcrw_format #(
    .WIDTH (WIDTH)
  ) u_format (
    .acc                  (accumulator),
    .justify_shift_select (justify_shift_select),
    .sample_bits_minus1   (sample_bits_minus1),
    .formatted            (formatted)
  );

  assign ref_ctrl = {internal_ref_level, 1'b0, ground_ref_select,
                     voltage_ref_select, temp_sensor_enable, 2'b00};

  always_comb begin
    next_rdata = 8'h00;
    next_hit   = page_ok;
    case (sfr_addr)
      adcrw_pkg::ADDR_RESULT_HI: next_rdata = formatted[15:8];
      adcrw_pkg::ADDR_RESULT_LO: next_rdata = formatted[7:0];
      adcrw_pkg::ADDR_UPPER_HI:  next_rdata = upper_limit[15:8];
      adcrw_pkg::ADDR_UPPER_LO:  next_rdata = upper_limit[7:0];
      adcrw_pkg::ADDR_LOWER_HI:  next_rdata = lower_limit[15:8];
      adcrw_pkg::ADDR_LOWER_LO:  next_rdata = lower_limit[7:0];
      adcrw_pkg::ADDR_CHAN_SEL:  next_rdata = {3'b000, positive_channel_select};
      adcrw_pkg::ADDR_REF_CTRL:  next_rdata = ref_ctrl & adcrw_pkg::REF_CTRL_MASK;
      default:                   next_hit   = 1'b0;
    endcase
    if (!page_ok) begin
      next_rdata = 8'h00;
    end
  end

  // registered read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_rdata <= sfr_rd ? next_rdata : 8'h00;
      sfr_hit   <= sfr_rd && next_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks: state at the first edge after reset is released; the first edge of
  // the run has no past value, so each reset check also waits for rst to drop
  a_upper_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> upper_limit == 16'hFFFF)
    else $error("upper threshold not all ones after reset");
  a_lower_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> lower_limit == 16'h0000)
    else $error("lower threshold not zero after reset");
  a_chan_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> positive_channel_select == 5'h1F && !channel_connected)
    else $error("channel select reset wrong");
  a_ref_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> voltage_ref_select == adcrw_pkg::ADCRW_REF_INT
      && !internal_ref_level && !ground_ref_select && !temp_sensor_enable)
    else $error("reference control reset wrong");
  a_acc_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> accumulator == 16'h0000)
    else $error("accumulator not zero after reset");
  a_read_reset: assert property (@(posedge core_clk)
    !rst && $past(rst) |-> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read port not idle after reset");

  // checks: accumulator bytes, converter load and software clear
  // a software byte must beat a converter load landing in the same cycle
  a_hi_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_RESULT_HI) |=> accumulator[15:8] == $past(sfr_wdata))
    else $error("high byte write lost");
  a_lo_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_RESULT_LO) |=> accumulator[7:0] == $past(sfr_wdata))
    else $error("low byte write lost");
  a_write_wins: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_RESULT_HI) && acc_load
    |=> accumulator == {$past(sfr_wdata), $past(acc_data[7:0])})
    else $error("converter load beat a software byte");
  a_acc_load: assert property (@(posedge core_clk) disable iff (rst)
    acc_load && !is_wr(adcrw_pkg::ADDR_RESULT_HI) && !is_wr(adcrw_pkg::ADDR_RESULT_LO)
    |=> accumulator == $past(acc_data))
    else $error("converter load lost");
  a_acc_hold: assert property (@(posedge core_clk) disable iff (rst)
    !acc_load && !is_wr(adcrw_pkg::ADDR_RESULT_HI) && !is_wr(adcrw_pkg::ADDR_RESULT_LO)
    |=> $stable(accumulator))
    else $error("accumulator changed without a load or write");
  a_clear_acc: assert property (@(posedge core_clk) disable iff (rst)
    (is_wr(adcrw_pkg::ADDR_RESULT_HI) && sfr_wdata == 8'h00)
    ##1 (is_wr(adcrw_pkg::ADDR_RESULT_LO) && sfr_wdata == 8'h00)
    |=> accumulator == ($past(acc_load) ? {$past(acc_data[15:8]), 8'h00} : 16'h0000))
    else $error("accumulator not cleared by zero writes");

  // checks: window thresholds
  a_up_hi_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_UPPER_HI) |=> upper_limit[15:8] == $past(sfr_wdata))
    else $error("upper threshold high byte write lost");
  a_up_lo_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_UPPER_LO) |=> upper_limit[7:0] == $past(sfr_wdata))
    else $error("upper threshold low byte write lost");
  a_low_hi_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_LOWER_HI) |=> lower_limit[15:8] == $past(sfr_wdata))
    else $error("lower threshold high byte write lost");
  a_low_lo_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_LOWER_LO) |=> lower_limit[7:0] == $past(sfr_wdata))
    else $error("lower threshold low byte write lost");
  a_limit_hold: assert property (@(posedge core_clk) disable iff (rst)
    !sfr_wr |=> $stable(upper_limit) && $stable(lower_limit))
    else $error("threshold changed without a write");
  a_limit_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_UPPER_LO
    |=> sfr_hit && sfr_rdata == $past(upper_limit[7:0]))
    else $error("upper threshold low byte read wrong");
  a_lower_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_LOWER_HI
    |=> sfr_hit && sfr_rdata == $past(lower_limit[15:8]))
    else $error("lower threshold high byte read wrong");
  a_lower_lo_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && sfr_page == adcrw_pkg::PAGE_LOW && sfr_addr == adcrw_pkg::ADDR_LOWER_LO
    |=> sfr_hit && sfr_rdata == $past(lower_limit[7:0]))
    else $error("first page not answered");
  a_page_high: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && sfr_page == adcrw_pkg::PAGE_HIGH && sfr_addr == adcrw_pkg::ADDR_UPPER_HI
    |=> sfr_hit && sfr_rdata == $past(upper_limit[15:8]))
    else $error("second page not answered");

  // checks: channel select
  a_chan_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_CHAN_SEL) |=> positive_channel_select == $past(sfr_wdata[4:0]))
    else $error("channel select write lost");
  a_chan_connect: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_CHAN_SEL) && sfr_wdata[4:0] <= adcrw_pkg::CHAN_LAST_VALID
    |=> channel_connected)
    else $error("valid channel left unconnected");
  a_reserved_chan: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_CHAN_SEL) && sfr_wdata[4:0] > adcrw_pkg::CHAN_LAST_VALID
    |=> !channel_connected)
    else $error("reserved channel code connected an input");
  a_chan_hold: assert property (@(posedge core_clk) disable iff (rst)
    !is_wr(adcrw_pkg::ADDR_CHAN_SEL)
    |=> $stable(positive_channel_select) && $stable(channel_connected))
    else $error("channel select changed without a write");
  a_chan_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_CHAN_SEL
    |=> sfr_hit && sfr_rdata == {3'b000, $past(positive_channel_select)})
    else $error("channel select read wrong");

  // checks: reference control
  a_ref_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_REF_CTRL)
    |=> temp_sensor_enable == $past(sfr_wdata[2])
      && ground_ref_select == $past(sfr_wdata[5]))
    else $error("reference control write lost");
  a_lvl_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_REF_CTRL) |=> internal_ref_level == $past(sfr_wdata[7]))
    else $error("reference level write lost");
  a_ref_sel_write: assert property (@(posedge core_clk) disable iff (rst)
    is_wr(adcrw_pkg::ADDR_REF_CTRL) |=> voltage_ref_select == $past(sfr_wdata[4:3]))
    else $error("reference select write lost");
  a_ref_hold: assert property (@(posedge core_clk) disable iff (rst)
    !is_wr(adcrw_pkg::ADDR_REF_CTRL)
    |=> $stable(internal_ref_level) && $stable(ground_ref_select)
      && $stable(voltage_ref_select) && $stable(temp_sensor_enable))
    else $error("reference control changed without a write");
  a_ref_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_REF_CTRL
    |=> sfr_rdata[7] == $past(internal_ref_level) && sfr_rdata[6] == 1'b0
      && sfr_rdata[5] == $past(ground_ref_select) && sfr_rdata[1:0] == 2'b00
      && sfr_rdata[4:3] == $past(voltage_ref_select) && sfr_rdata[2] == $past(temp_sensor_enable))
    else $error("reference control read wrong");

  // checks: read formatting and the read port
  a_hi_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_RESULT_HI
    |=> sfr_rdata == $past(formatted[15:8]) && sfr_hit)
    else $error("high byte read wrong");
  a_lo_read: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == adcrw_pkg::ADDR_RESULT_LO
    |=> sfr_rdata == $past(formatted[7:0]) && sfr_hit)
    else $error("low byte read wrong");
  a_no_shift: assert property (@(posedge core_clk) disable iff (rst)
    justify_shift_select == adcrw_pkg::JS_RIGHT_0 |-> formatted == accumulator)
    else $error("unshifted read altered");
  a_shift_one: assert property (@(posedge core_clk) disable iff (rst)
    justify_shift_select == 3'h1 |-> formatted == {1'b0, accumulator[15:1]})
    else $error("one-bit shift wrong");
  a_shift_two: assert property (@(posedge core_clk) disable iff (rst)
    justify_shift_select == 3'h2 |-> formatted == {2'b00, accumulator[15:2]})
    else $error("two-bit shift wrong");
  a_shift_zero: assert property (@(posedge core_clk) disable iff (rst)
    justify_shift_select == 3'h3 |-> formatted[15:13] == 3'b000)
    else $error("shifted read top bits not zero");
  a_left_justify: assert property (@(posedge core_clk) disable iff (rst)
    justify_shift_select == adcrw_pkg::JS_LEFT && sample_bits_minus1 == 4'hB
    |-> formatted == {accumulator[11:0], 4'h0})
    else $error("left justified read wrong");
  a_bad_page: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && !page_ok |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("answer on foreign page");
  a_unmapped: assert property (@(posedge core_clk) disable iff (rst)
    sfr_rd && !next_hit |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("answer on unmapped address");
  a_no_read: assert property (@(posedge core_clk) disable iff (rst)
    !sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read port active without a read");

  // main scenarios
  c_clear_acc: cover property (@(posedge core_clk)
    is_wr(adcrw_pkg::ADDR_RESULT_HI) ##1 is_wr(adcrw_pkg::ADDR_RESULT_LO));
  c_left_read: cover property (@(posedge core_clk)
    sfr_rd && justify_shift_select == adcrw_pkg::JS_LEFT);
  c_reserved_chan: cover property (@(posedge core_clk)
    is_wr(adcrw_pkg::ADDR_CHAN_SEL) ##1 !channel_connected);
  c_shift_read: cover property (@(posedge core_clk)
    sfr_rd && page_ok && justify_shift_select == adcrw_pkg::JS_RIGHT_3);
  c_window_write: cover property (@(posedge core_clk)
    is_wr(adcrw_pkg::ADDR_UPPER_HI) ##1 is_wr(adcrw_pkg::ADDR_UPPER_LO));

endmodule // adcrw_regs

// ---- verif/adc_result_window_ref_regs_tb.sv ----
// self-checking bench for the result, window, channel and reference register bank
////////////////////////////////////////////////////////////////////////////////
// compare one value against its expected value, counting checks and mismatches
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module adc_result_window_ref_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // run is about 3040 steps; the ceiling leaves a generous margin
  localparam int                 LIMIT = 5000;
  localparam logic [7:0]         ADDRS [8] = '{8'hBB, 8'hBD, 8'hBE, 8'hC3,
                                               8'hC4, 8'hC5, 8'hC6, 8'hD1};
  logic                          core_clk = 1'b0;
  logic                          rst = 1'b1;
  logic [7:0]                    sfr_page = 8'h00;
  logic [7:0]                    sfr_addr = 8'h00;
  logic                          sfr_wr = 1'b0;
  logic                          sfr_rd = 1'b0;
  logic [7:0]                    sfr_wdata = 8'h00;
  logic [7:0]                    sfr_rdata;
  logic                          sfr_hit;
  logic                          acc_load = 1'b0;
  logic [15:0]                   acc_data = 16'h0000;
  logic [2:0]                    justify_shift_select = 3'h0;
  logic [3:0]                    sample_bits_minus1 = 4'hB;
  logic [15:0]                   accumulator;
  logic [15:0]                   upper_limit;
  logic [15:0]                   lower_limit;
  logic [4:0]                    positive_channel_select;
  logic                          channel_connected;
  logic                          internal_ref_level;
  logic                          ground_ref_select;
  adcrw_pkg::adcrw_ref_type      voltage_ref_select;
  logic                          temp_sensor_enable;
  int                            miscompares = 0;
  int                            num_checks = 0;
  int                            cycles = 0;
  // behavioural model state, starting from the documented reset values
  logic [15:0]                   m_acc = 16'h0000;
  logic [15:0]                   m_up = 16'hFFFF;
  logic [15:0]                   m_lo = 16'h0000;
  logic [4:0]                    m_chan = 5'h1F;
  logic [7:0]                    m_ref = 8'h18;
  logic [7:0]                    e_rdata = 8'h00;
  logic                          e_hit = 1'b0;

  adcrw_regs u_adcrw_regs (
    .core_clk(core_clk), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .acc_load(acc_load), .acc_data(acc_data),
    .justify_shift_select(justify_shift_select), .sample_bits_minus1(sample_bits_minus1),
    .accumulator(accumulator), .upper_limit(upper_limit), .lower_limit(lower_limit),
    .positive_channel_select(positive_channel_select), .channel_connected(channel_connected),
    .internal_ref_level(internal_ref_level), .ground_ref_select(ground_ref_select),
    .voltage_ref_select(voltage_ref_select), .temp_sensor_enable(temp_sensor_enable));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // hang guard: a run that overstays counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  // read formatting: right shift fills zeros on top, code 4 left justifies
  function automatic logic [15:0] fmt(input logic [15:0] a);
    if (justify_shift_select <= adcrw_pkg::JS_RIGHT_3) return a >> justify_shift_select;
    if (justify_shift_select == adcrw_pkg::JS_LEFT) return a << (4'hF - sample_bits_minus1);
    return a;
  endfunction

  // model read: top bit says the address is mapped
  function automatic logic [8:0] rd(input logic [7:0] a);
    logic [15:0] f;
    f = fmt(m_acc);
    case (a)
      8'hBB: return {1'b1, 3'h0, m_chan};
      8'hBD: return {1'b1, f[7:0]};
      8'hBE: return {1'b1, f[15:8]};
      8'hC3: return {1'b1, m_up[7:0]};
      8'hC4: return {1'b1, m_up[15:8]};
      8'hC5: return {1'b1, m_lo[7:0]};
      8'hC6: return {1'b1, m_lo[15:8]};
      8'hD1: return {1'b1, m_ref};
      default: return 9'h000;
    endcase
  endfunction

  // one cycle: check what the last edge produced, then drive the next request
  task automatic step(input int op, input logic [7:0] pg, input logic [7:0] ad,
                      input logic [7:0] d);
    logic       ok;
    logic [8:0] r;
    @(negedge core_clk);
    `CHK(sfr_hit, e_hit)
    `CHK(sfr_rdata, e_rdata)
    `CHK(accumulator, m_acc)
    `CHK({upper_limit, lower_limit}, {m_up, m_lo})
    `CHK({channel_connected, positive_channel_select}, {(m_chan <= 5'h13), m_chan})
    `CHK({internal_ref_level, ground_ref_select, voltage_ref_select, temp_sensor_enable},
         {m_ref[7], m_ref[5], m_ref[4:3], m_ref[2]})
    ok = (pg == adcrw_pkg::PAGE_LOW) || (pg == adcrw_pkg::PAGE_HIGH);
    if (ad == 8'hBB) d = d & 8'h1F;
    if (ad == 8'hD1) d = d & adcrw_pkg::REF_CTRL_MASK;
    sfr_page = pg;
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = (op == 1);
    sfr_rd = (op == 2);
    justify_shift_select = 3'($urandom);
    sample_bits_minus1 = 4'($urandom);
    acc_data = 16'($urandom);
    acc_load = (op != 2) && ($urandom % 4 == 0);
    r = rd(ad);
    e_hit = (op == 2) && ok && r[8];
    e_rdata = e_hit ? r[7:0] : 8'h00;
    if (acc_load) m_acc = acc_data;
    // a register write in the same cycle wins over the converter load for its byte
    if (op == 1 && ok) begin
      case (ad)
        8'hBB: m_chan = d[4:0];
        8'hBD: m_acc[7:0] = d;
        8'hBE: m_acc[15:8] = d;
        8'hC3: m_up[7:0] = d;
        8'hC4: m_up[15:8] = d;
        8'hC5: m_lo[7:0] = d;
        8'hC6: m_lo[15:8] = d;
        8'hD1: m_ref = d;
        default: ;
      endcase
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, reset-value reads, random traffic, accumulator clear
  initial begin
    logic [7:0] pg;
    void'($urandom(60));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) step(2, 8'h10, ADDRS[i], 8'h00);
    step(2, 8'h00, 8'hBC, 8'h00);
    // pages outside the two accepted ones and unmapped addresses must be refused
    for (int i = 0; i < 3000; i++) begin
      case ($urandom % 5)
        0, 1: pg = 8'h00;
        2, 3: pg = 8'h10;
        default: pg = 8'($urandom);
      endcase
      step($urandom % 3, pg, ($urandom % 10 < 8) ? ADDRS[$urandom % 8] : 8'($urandom),
           8'($urandom));
    end
    step(1, 8'h00, 8'hBE, 8'h00);
    step(1, 8'h10, 8'hBD, 8'h00);
    step(2, 8'h00, 8'hBE, 8'h00);
    step(0, 8'h00, 8'h00, 8'h00);
    // second reset in mid-run: bank and model both go back to reset values
    @(negedge core_clk);
    rst = 1'b1;
    acc_load = 1'b0;
    m_acc = 16'h0000;
    m_up = 16'hFFFF;
    m_lo = 16'h0000;
    m_chan = 5'h1F;
    m_ref = 8'h18;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) step(2, 8'h00, ADDRS[i], 8'h00);
    // eight-bit mode setup: software clears both threshold low bytes
    step(1, 8'h00, 8'hC3, 8'h00);
    step(1, 8'h10, 8'hC5, 8'h00);
    step(2, 8'h00, 8'hC3, 8'h00);
    step(2, 8'h10, 8'hC5, 8'h00);
    step(0, 8'h00, 8'h00, 8'h00);
    step(0, 8'h00, 8'h00, 8'h00);
    conclude();
  end
endmodule // adc_result_window_ref_regs_tb
